// ==== core/tis_regs.sv ====
// apb register block for address invalidation commands and sync
`timescale 1ns/10ps
`default_nettype none
`include "tis_cfg.svh"
module tis_regs (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`TIS_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic INV_VALID,
    output tis_pkg::tis_inv_req_t INV_REQ,
    input wire logic INV_READY,
    input wire logic INV_DONE,
    output logic SYNC_ACTIVE
);

    // =========================================
    // state
    tis_pkg::tis_apb_st_t st_q;
    tis_pkg::tis_apb_st_t st_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] hi_q;
    logic [31:0] hi_d;
    logic [2:0] hi_own_q;
    logic [2:0] hi_own_d;
    logic inv_valid_q;
    logic inv_valid_d;
    tis_pkg::tis_inv_req_t inv_req_q;
    tis_pkg::tis_inv_req_t inv_req_d;

    // =========================================
    // decode
    logic access;
    logic commit;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_sync;
    logic [2:0] sel_lo;
    logic [2:0] sel_hi;
    logic mapped;
    logic is_issue;
    logic sync_pulse;
    logic issue_pulse;
    logic wide;
    logic sync_act;

    assign access = PSEL && PENABLE;
    assign commit = access && pready_q && (st_q == tis_pkg::TIS_ST_RESP);
    assign wide = ctrl_q[`TIS_CTRL_WIDE];

    always_comb begin
        sel_ctrl = 1'b0;
        sel_stat = 1'b0;
        sel_sync = 1'b0;
        sel_lo = 3'b000;
        sel_hi = 3'b000;
        if (PADDR == `TIS_OFF_CTRL) begin
            sel_ctrl = 1'b1;
        end else if (PADDR == `TIS_OFF_STATUS) begin
            sel_stat = 1'b1;
        end else if (PADDR == `TIS_OFF_SYNC) begin
            sel_sync = 1'b1;
        end else if (PADDR == `TIS_OFF_VAA_LO) begin
            sel_lo = 3'b001;
        end else if (PADDR == `TIS_OFF_VAA_HI) begin
            sel_hi = 3'b001;
        end else if (PADDR == `TIS_OFF_VAAL_LO) begin
            sel_lo = 3'b010;
        end else if (PADDR == `TIS_OFF_VAAL_HI) begin
            sel_hi = 3'b010;
        end else if (PADDR == `TIS_OFF_VAL_LO) begin
            sel_lo = 3'b100;
        end else if (PADDR == `TIS_OFF_VAL_HI) begin
            sel_hi = 3'b100;
        end
    end

    assign mapped = sel_ctrl || sel_stat || sel_sync || (sel_lo != 3'b000) || (sel_hi != 3'b000);
    // a low-word command write is the one that issues
    assign is_issue = PWRITE && (sel_lo != 3'b000);
    assign sync_pulse = commit && PWRITE && sel_sync && CE; // [RQ21]
    assign issue_pulse = commit && is_issue && CE;

    // =========================================
    // request building
    function automatic logic [63:0] tis_build_va(
        input logic w,
        input logic [63:0] d,
        input logic [1:0] gran
    );
        logic [63:0] va;
        va = 64'h0;
        if (w) begin
            // sign copy from bit 55 only, position setting unused
            va = {{8{d[`TIS_W_ADDR_HI]}}, d[`TIS_W_ADDR_HI:0], 12'h000}; // [RQ1] [RQ4]
        end else begin
            va = {32'h0, d[`TIS_N_VA_HI:`TIS_N_VA_LO], 12'h000}; // [RQ5] [RQ18]
        end
        if (gran == `TIS_GRAN_64K) begin
            va[15:12] = 4'h0; // [RQ2]
        end else if (gran == `TIS_GRAN_16K) begin
            va[13:12] = 2'h0; // [RQ3]
        end
        return va;
    endfunction : tis_build_va

    logic [63:0] cmd_data;
    logic use_hi;
    logic hyp;
    logic mon;
    logic sec;
    logic [15:0] asid_w;
    tis_pkg::tis_inv_req_t req_new;

    assign hyp = ctrl_q[`TIS_CTRL_HYP];
    assign mon = ctrl_q[`TIS_CTRL_MON];
    assign sec = ctrl_q[`TIS_CTRL_SEC];
    // upper half only counts when staged just before for the same register
    assign use_hi = wide && (hi_own_q == sel_lo);

    always_comb begin
        if (use_hi) begin
            cmd_data = {hi_q, PWDATA};
        end else begin
            cmd_data = {32'h0, PWDATA}; // [RQ11] [RQ12]
        end
    end

    always_comb begin
        asid_w = cmd_data[`TIS_W_ASID_HI:`TIS_W_ASID_LO];
        if (!ctrl_q[`TIS_CTRL_WID]) begin
            asid_w[15:8] = 8'h00;
        end
    end

    always_comb begin
        req_new = '0;
        req_new.va = tis_build_va(wide, cmd_data, ctrl_q[`TIS_CTRL_GRAN_HI:`TIS_CTRL_GRAN_LO]);
        req_new.granule = ctrl_q[`TIS_CTRL_GRAN_HI:`TIS_CTRL_GRAN_LO];
        req_new.vmid = ctrl_q[`TIS_CTRL_VMID_HI:`TIS_CTRL_VMID_LO];
        req_new.secure = sec; // [RQ9]
        req_new.hyp = hyp || mon;
        // secure and hypervisor banks skip the machine id
        req_new.check_vmid = !sec && !hyp && !mon; // [RQ7] [RQ9] [RQ15]
        req_new.cmd = tis_pkg::TIS_CMD_VAA;
        req_new.last_level = 1'b0;
        req_new.check_asid = 1'b0;
        req_new.asid = 16'h0000;
        if (sel_lo[1]) begin
            // any identifier, globals included, final-level only
            req_new.cmd = tis_pkg::TIS_CMD_VAAL; // [RQ6]
            req_new.last_level = 1'b1; // [RQ7]
            // hypervisor or monitor bank: still issued last-level, machine id skipped
            req_new.check_vmid = !sec && !hyp && !mon; // [RQ8] [RQ10]
        end else if (sel_lo[2]) begin
            req_new.cmd = tis_pkg::TIS_CMD_VAL;
            req_new.last_level = 1'b1; // [RQ14]
            req_new.check_asid = !hyp && !mon; // [RQ14] [RQ15]
            if (wide) begin
                req_new.asid = asid_w;
            end else begin
                req_new.asid = {8'h00, cmd_data[`TIS_N_ASID_HI:0]}; // [RQ18]
            end
        end
    end

    // =========================================
    // apb slave
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000; // [RQ13] [RQ22]
        if (sel_ctrl) begin
            rdata = ctrl_q & `TIS_CTRL_MASK;
        end else if (sel_stat) begin
            rdata[`TIS_SYNC_BIT] = sync_act; // [RQ19] [RQ20]
        end
    end

    always_comb begin
        st_d = st_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        case (st_q)
            tis_pkg::TIS_ST_IDLE: begin
                // low-word command write waits while the slot is still full
                if (access && !(is_issue && inv_valid_q)) begin
                    st_d = tis_pkg::TIS_ST_RESP;
                    pready_d = 1'b1;
                    pslverr_d = !mapped;
                    prdata_d = PWRITE ? 32'h0000_0000 : rdata;
                end
            end
            tis_pkg::TIS_ST_RESP: begin
                if (commit) begin
                    st_d = tis_pkg::TIS_ST_IDLE;
                end else begin
                    pready_d = pready_q;
                    pslverr_d = pslverr_q;
                end
            end
            default: begin
                st_d = tis_pkg::TIS_ST_IDLE;
            end
        endcase
    end

    // =========================================
    // register writes
    always_comb begin
        ctrl_d = ctrl_q;
        hi_d = hi_q;
        hi_own_d = hi_own_q;
        if (commit) begin
            hi_own_d = 3'b000;
            if (PWRITE && sel_ctrl) begin
                ctrl_d = PWDATA & `TIS_CTRL_MASK;
            end else if (PWRITE && (sel_hi != 3'b000) && wide) begin
                hi_d = PWDATA;
                hi_own_d = sel_hi; // [RQ11]
            end
        end
    end

    // =========================================
    // invalidate slot
    always_comb begin
        inv_valid_d = inv_valid_q;
        inv_req_d = inv_req_q;
        if (inv_valid_q && INV_READY) begin
            inv_valid_d = 1'b0;
        end
        if (commit && is_issue) begin
            inv_valid_d = 1'b1;
            inv_req_d = req_new;
        end
    end

    // =========================================
    // flops
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= tis_pkg::TIS_ST_IDLE;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q <= `TIS_CTRL_RST;
            hi_q <= 32'h0000_0000;
            hi_own_q <= 3'b000;
            inv_valid_q <= 1'b0;
            inv_req_q <= '0;
        end else if (CE) begin
            st_q <= st_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_q <= ctrl_d;
            hi_q <= hi_d;
            hi_own_q <= hi_own_d;
            inv_valid_q <= inv_valid_d;
            inv_req_q <= inv_req_d;
        end
    end

    // =========================================
    // sync tracking
    tis_sync_track u_track (
        .clk(MCLK),
        .rst_n(RST_N),
        .ce(CE),
        .issue(issue_pulse),
        .done(INV_DONE && CE),
        .sync(sync_pulse),
        .active(sync_act)
    );

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign INV_VALID = inv_valid_q;
    assign INV_REQ = inv_req_q;
    assign SYNC_ACTIVE = sync_act;

endmodule : tis_regs
`default_nettype wire

// ==== core/tis_cfg.svh ====
// constants for the translation-cache invalidate and sync registers
// Functional notes
// RQ1: wide format: bits 43:0 give address 55:12
// RQ2: 64KB granule ignores address bits 15:12
// RQ3: 16KB granule ignores address bits 13:12
// RQ4: extend from bit 55 only, no other
// RQ5: narrow all-identifier: address 31:12, 11:0 reserved
// RQ6: last-level all-identifier hits any identifier, globals too
// RQ7: last-level only; non-secure non-hypervisor checks machine id
// RQ8: hypervisor or monitor bank: last-level all-identifier undefined
// RQ9: own security state; secure banks skip machine id
// RQ10: over-invalidation of any unlocked entries allowed
// RQ11: wide format 32-bit writes: upper ignored, lower zero-extended
// RQ12: narrow format ignores upper 32 bits
// RQ13: command registers write-only, read zero
// RQ14: last-level by-identifier matches address and identifier
// RQ15: hypervisor bank ignores machine and space identifiers
// RQ16: software keeps identifier upper byte zero when narrow
// RQ17: software writes identifier zero in hypervisor/monitor banks
// RQ18: narrow by-identifier: address 31:12, identifier 7:0
// RQ19: sync status read-only, resets zero, writes ignored
// RQ20: status bit 0 set while pre-sync invalidations pending
// RQ21: sync waits for all earlier accepted invalidations
// RQ22: sync command write-only, reads zero
// RQ23: status set at once on sync acceptance
// RQ24: software syncs then polls status before relying
`ifndef TIS_CFG_SVH
`define TIS_CFG_SVH

`define TIS_AW 12
`define TIS_OFF_CTRL 12'h000
`define TIS_OFF_STATUS 12'h004
`define TIS_OFF_SYNC 12'h008
`define TIS_OFF_VAA_LO 12'h010
`define TIS_OFF_VAA_HI 12'h014
`define TIS_OFF_VAAL_LO 12'h018
`define TIS_OFF_VAAL_HI 12'h01C
`define TIS_OFF_VAL_LO 12'h020
`define TIS_OFF_VAL_HI 12'h024

`define TIS_CTRL_RST 32'h0000_0000
`define TIS_CTRL_MASK 32'hFFFF_007F
`define TIS_CTRL_WIDE 0
`define TIS_CTRL_HYP 1
`define TIS_CTRL_MON 2
`define TIS_CTRL_WID 3
`define TIS_CTRL_SEC 4
`define TIS_CTRL_GRAN_LO 5
`define TIS_CTRL_GRAN_HI 6
`define TIS_CTRL_VMID_LO 16
`define TIS_CTRL_VMID_HI 31

`define TIS_GRAN_16K 2'h1
`define TIS_GRAN_64K 2'h2

`define TIS_W_ADDR_HI 43
`define TIS_W_ASID_LO 48
`define TIS_W_ASID_HI 63
`define TIS_N_VA_LO 12
`define TIS_N_VA_HI 31
`define TIS_N_ASID_HI 7
`define TIS_SYNC_BIT 0
`define TIS_CNT_W 8

`endif

// ==== core/tis_pkg.sv ====
// types shared by the invalidate and sync register block
package tis_pkg;

    typedef enum logic [2:0] {
        TIS_CMD_VAA = 3'b001,
        TIS_CMD_VAAL = 3'b010,
        TIS_CMD_VAL = 3'b100
    } tis_cmd_t;

    typedef enum logic [1:0] {
        TIS_ST_IDLE = 2'b01,
        TIS_ST_RESP = 2'b10
    } tis_apb_st_t;

    typedef struct packed {
        tis_cmd_t cmd;
        logic [63:0] va;
        logic [15:0] asid;
        logic [15:0] vmid;
        logic [1:0] granule;
        logic check_asid;
        logic check_vmid;
        logic last_level;
        logic secure;
        logic hyp;
    } tis_inv_req_t;

endpackage : tis_pkg

// ==== core/tis_sync_track.sv ====
// outstanding-invalidation counter and sync-active tracking
`timescale 1ns/10ps
`default_nettype none
`include "tis_cfg.svh"
module tis_sync_track (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic issue,
    input wire logic done,
    input wire logic sync,
    output logic active
);

    logic [`TIS_CNT_W-1:0] out_q;
    logic [`TIS_CNT_W-1:0] out_d;
    logic [`TIS_CNT_W-1:0] sync_q;
    logic [`TIS_CNT_W-1:0] sync_d;
    logic act_q;
    logic act_d;

    // =========================================
    // next state
    always_comb begin
        out_d = out_q;
        if (issue && !done) begin
            out_d = out_q + `TIS_CNT_W'(1);
        end else if (!issue && done && out_q != '0) begin
            out_d = out_q - `TIS_CNT_W'(1);
        end
        sync_d = sync_q;
        if (sync) begin
            sync_d = out_d; // [RQ21] [RQ23]
        end else if (done && sync_q != '0) begin
            sync_d = sync_q - `TIS_CNT_W'(1); // [RQ21]
        end
        act_d = (sync_d != '0); // [RQ20]
    end

    // =========================================
    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '0;
            sync_q <= '0;
            act_q <= 1'b0; // [RQ19]
        end else if (ce) begin
            out_q <= out_d;
            sync_q <= sync_d;
            act_q <= act_d;
        end
    end

    assign active = act_q;

endmodule : tis_sync_track
`default_nettype wire

// ==== dv/tis_regs_sva.sv ====
// assertion checker for the invalidate and sync register block
`timescale 1ns/10ps
`default_nettype none
`include "tis_cfg.svh"
module tis_regs_sva (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`TIS_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic INV_VALID,
    input wire tis_pkg::tis_inv_req_t INV_REQ,
    input wire logic INV_READY,
    input wire logic INV_DONE,
    input wire logic SYNC_ACTIVE
);
    // ========
    // properties
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    logic acc;
    assign acc = PSEL && PENABLE && PREADY;
    AST_LOW_ZERO: assert property (INV_VALID |-> INV_REQ.va[11:0] == 12'h000)
        else $error("request address low bits not zero");
    AST_GRAN_64K: assert property (INV_VALID && INV_REQ.granule == `TIS_GRAN_64K |-> INV_REQ.va[15:12] == 4'h0)
        else $error("64K granule bits not cleared");
    AST_GRAN_16K: assert property (INV_VALID && INV_REQ.granule == `TIS_GRAN_16K |-> INV_REQ.va[13:12] == 2'h0)
        else $error("16K granule bits not cleared");
    AST_SIGN_EXT: assert property (INV_VALID |-> INV_REQ.va[63:56] == {8{INV_REQ.va[55]}})
        else $error("address not extended from bit 55");
    AST_LAST_LEVEL: assert property (INV_VALID |-> INV_REQ.last_level == (INV_REQ.cmd != tis_pkg::TIS_CMD_VAA))
        else $error("last level flag wrong for command");
    AST_ALL_ID: assert property (INV_VALID && INV_REQ.cmd != tis_pkg::TIS_CMD_VAL |-> !INV_REQ.check_asid)
        else $error("identifier checked on all-identifier command");
    AST_SECURE_VMID: assert property (INV_VALID && INV_REQ.secure |-> !INV_REQ.check_vmid)
        else $error("machine id checked in secure bank");
    AST_REQ_HOLD: assert property (INV_VALID && !INV_READY |=> INV_VALID && $stable(INV_REQ))
        else $error("pending request dropped or changed");
    AST_CMD_READ_ZERO: assert property (acc && !PWRITE && (PADDR == `TIS_OFF_SYNC ||
        (PADDR >= `TIS_OFF_VAA_LO && PADDR <= `TIS_OFF_VAL_HI)) |-> PRDATA == 32'h0)
        else $error("command register read not zero");
    AST_STATUS_RSVD: assert property (acc && !PWRITE && PADDR == `TIS_OFF_STATUS |-> PRDATA[31:1] == 31'h0)
        else $error("status reserved bits not zero");
    AST_SYNC_SET: assert property ($rose(SYNC_ACTIVE) |-> $past(acc && PWRITE && PADDR == `TIS_OFF_SYNC))
        else $error("sync active rose without sync write");
    AST_SYNC_CLEAR: assert property ($fell(SYNC_ACTIVE) |-> $past(INV_DONE))
        else $error("sync active fell without completion");
endmodule : tis_regs_sva
bind tis_regs tis_regs_sva u_sva (.MCLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .INV_VALID, .INV_REQ, .INV_READY, .INV_DONE, .SYNC_ACTIVE);
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the invalidate and sync register block
`timescale 1ns/10ps
`default_nettype none
`include "tis_cfg.svh"
module tb_top;
    logic MCLK, RST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, INV_VALID, INV_READY, INV_DONE, SYNC_ACTIVE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, r, rb, ctl;
    logic [63:0] d;
    tis_pkg::tis_inv_req_t INV_REQ;
    integer seed = 33096;
    int mismatches = 0;
    int checks_done = 0;
    int pend = 0;
    logic [32:0] rq[$];
    logic [32:0] ex;
    tis_pkg::tis_inv_req_t iq[$];
    tis_pkg::tis_cmd_t cmds[3] = '{tis_pkg::TIS_CMD_VAA, tis_pkg::TIS_CMD_VAAL, tis_pkg::TIS_CMD_VAL};
    logic [11:0] los[3] = '{`TIS_OFF_VAA_LO, `TIS_OFF_VAAL_LO, `TIS_OFF_VAL_LO};
    logic [11:0] offs[9] = '{`TIS_OFF_CTRL, `TIS_OFF_STATUS, `TIS_OFF_SYNC, `TIS_OFF_VAA_LO, `TIS_OFF_VAA_HI,
        `TIS_OFF_VAAL_LO, `TIS_OFF_VAAL_HI, `TIS_OFF_VAL_LO, `TIS_OFF_VAL_HI};

    tis_regs dut (.MCLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .INV_VALID, .INV_REQ, .INV_READY, .INV_DONE, .SYNC_ACTIVE);

    always #20 MCLK = ~MCLK;

    always @(posedge MCLK) begin
        rb = $random(seed);
        INV_READY <= rb[0];
    end

    // ========
    // helpers
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task chk(input logic [127:0] s, input logic [127:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    function automatic tis_pkg::tis_inv_req_t exp_inv(input tis_pkg::tis_cmd_t c, input logic [31:0] f,
        input logic [63:0] x);
        tis_pkg::tis_inv_req_t e;
        e = '0;
        e.cmd = c;
        e.va = f[0] ? {{8{x[43]}}, x[43:0], 12'h000} : {32'h0, x[31:12], 12'h000};
        if (f[6:5] == `TIS_GRAN_16K) e.va[13:12] = 2'h0;
        if (f[6:5] == `TIS_GRAN_64K) e.va[15:12] = 4'h0;
        if (c == tis_pkg::TIS_CMD_VAL) e.asid = f[0] ? x[63:48] : {8'h00, x[7:0]};
        e.vmid = f[31:16];
        e.granule = f[6:5];
        e.secure = f[4];
        e.hyp = f[1] || f[2];
        e.last_level = c != tis_pkg::TIS_CMD_VAA;
        e.check_asid = c == tis_pkg::TIS_CMD_VAL && !e.hyp;
        e.check_vmid = !f[4] && !e.hyp;
        return e;
    endfunction : exp_inv

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
        int n;
        rq.push_back(e);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            summarize();
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask : apb

    task automatic inv(input int c, input logic [31:0] cf, input logic hi, input logic [63:0] x);
        iq.push_back(exp_inv(cmds[c], cf, x));
        if (hi) apb(1'b1, los[c] + 12'h004, x[63:32], 33'h0);
        apb(1'b1, los[c], x[31:0], 33'h0);
    endtask : inv

    task automatic waitq(input int n);
        int k;
        k = 0;
        while ((pend != n || INV_VALID !== 1'b0) && k < 300) begin
            @(posedge MCLK);
            k++;
        end
        if (k >= 300) begin
            mismatches++;
            summarize();
        end
    endtask : waitq

    task automatic fin(input int n);
        repeat (n) begin
            INV_DONE <= 1'b1;
            @(posedge MCLK);
            INV_DONE <= 1'b0;
            pend--;
            @(posedge MCLK);
        end
    endtask : fin

    always @(posedge MCLK) begin
        if (RST_N && PSEL && PENABLE && PREADY === 1'b1) begin
            ex = rq.size() > 0 ? rq.pop_front() : 'x;
            chk(128'({PSLVERR, PWRITE ? 32'h0 : PRDATA}), 128'(ex));
            if (!PWRITE && PADDR == `TIS_OFF_STATUS) chk(128'(SYNC_ACTIVE), 128'(ex[0]));
        end
        if (RST_N && INV_VALID === 1'b1 && INV_READY === 1'b1) begin
            pend++;
            chk(128'(INV_REQ), iq.size() > 0 ? 128'(iq.pop_front()) : 'x);
        end
    end

    initial begin
        repeat (100000) @(posedge MCLK);
        mismatches++;
        summarize();
    end

    // ========
    // main sequence
    initial begin
        {MCLK, RST_N, PSEL, PENABLE, PWRITE, INV_DONE} = 6'h00;
        CE = 1'b1;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        repeat (8) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        foreach (offs[i]) apb(1'b0, offs[i], 32'h0, 33'h0);
        apb(1'b0, 12'h030, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h011, 32'h5A, {1'b1, 32'h0});
        $display("test reset and map done");
        for (int k = 0; k < 12; k++) begin
            r = $random(seed);
            d = {$random(seed), $random(seed)};
            ctl = {r[31:16], 9'h000, 2'(k % 3), r[4], k >= 6, r[2:1], 1'(k % 2)};
            if (!ctl[3]) d[63:56] = 8'h00;
            if (ctl[2:1] != 2'b00) begin
                d[63:48] = 16'h0000;
                d[7:0] = 8'h00;
            end
            if (ctl[0] && k % 4 == 1) d[63:32] = 32'h0;
            apb(1'b1, `TIS_OFF_CTRL, ctl, 33'h0);
            apb(1'b0, `TIS_OFF_CTRL, 32'h0, {1'b0, ctl & `TIS_CTRL_MASK});
            inv(k % 3, ctl, k % 4 != 1, d);
        end
        waitq(12);
        fin(12);
        $display("test commands done");
        apb(1'b1, `TIS_OFF_CTRL, 32'h0, 33'h0);
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            inv(0, 32'h0, 1'b0, {32'h0, r});
        end
        waitq(3);
        apb(1'b1, `TIS_OFF_SYNC, 32'h0, 33'h0);
        apb(1'b0, `TIS_OFF_STATUS, 32'h0, 33'h1);
        apb(1'b1, `TIS_OFF_STATUS, 32'hFFFF_FFFF, 33'h0);
        apb(1'b0, `TIS_OFF_STATUS, 32'h0, 33'h1);
        fin(2);
        // a completion while frozen is not counted
        CE <= 1'b0;
        INV_DONE <= 1'b1;
        @(posedge MCLK);
        CE <= 1'b1;
        INV_DONE <= 1'b0;
        @(posedge MCLK);
        apb(1'b0, `TIS_OFF_STATUS, 32'h0, 33'h1);
        r = $random(seed);
        inv(1, 32'h0, 1'b0, {32'h0, r});
        waitq(2);
        fin(1);
        apb(1'b0, `TIS_OFF_STATUS, 32'h0, 33'h0);
        apb(1'b1, `TIS_OFF_SYNC, 32'h0, 33'h0);
        apb(1'b0, `TIS_OFF_STATUS, 32'h0, 33'h1);
        fin(1);
        apb(1'b0, `TIS_OFF_STATUS, 32'h0, 33'h0);
        apb(1'b1, `TIS_OFF_SYNC, 32'h0, 33'h0);
        apb(1'b0, `TIS_OFF_STATUS, 32'h0, 33'h0);
        $display("test sync done");
        summarize();
    end
endmodule : tb_top
`default_nettype wire
